// ==== test/line_side_model.sv ====
// behavioural line-side chip that presents ring levels to the register bank
`timescale 1ns/1ps

module line_side_model
(
  input wire logic mclk,
  input wire logic [1:0] ring_cmd,
  input wire logic line_side_powerdown,
  output logic ring_neg,
  output logic ring_pos
);
  // ---------------------------------------------------------------
  // ring detector
  // ---------------------------------------------------------------
  // ring levels leave the line chip on a clock edge, as across the link;
  // a powered-down line chip reports no ring, hook state is not gated so
  // that a ring while off-hook stays testable
  always_ff @(posedge mclk)
  begin
    ring_neg <= ring_cmd[1] & ~line_side_powerdown;
    ring_pos <= ring_cmd[0] & ~line_side_powerdown;
  end
endmodule

// ==== test/tb_line_interface_control_regs.sv ====
// self-checking bench for the line interface control register bank
`timescale 1ns/1ps
`include "line_if_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_line_interface_control_regs
  import line_if_pkg::*;
;
  localparam logic [7:0] A5 = {`IDX_CTRL_ONE, 2'b00};
  localparam logic [7:0] A6 = {`IDX_CTRL_TWO, 2'b00};
  localparam logic [7:0] A7 = {`IDX_RSVD_SEVEN, 2'b00};
  localparam logic [7:0] AST = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] AMK = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] ACF = {`IDX_CONFIG, 2'b00};
  logic mclk = 0, rstn = 0, avs_read = 0, avs_write = 0, offhook_pin = 0, ce = 1;
  logic [3:0] avs_byteenable = 4'hf;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, seed = 32'd96;
  logic [1:0] ring_cmd = 0;
  wire [31:0] avs_readdata;
  wire [5:0] tx_atten_db, rx_atten_db;
  wire avs_waitrequest, offhook_out, onhook_monitor, line_side_powerdown;
  wire system_side_powerdown, tx_mute, rx_mute, irq, ring_neg, ring_pos;
  int n_mismatch = 0, samples_checked = 0;
  reg8_t q, v;

  line_interface_control_regs #(.RING_HOLD_CYC(30'd20), .OFFHOOK_HOLD_CYC(17'd8)) dut (
    .mclk(mclk), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ring_neg_in(ring_neg), .ring_pos_in(ring_pos), .offhook_pin(offhook_pin),
    .offhook_out(offhook_out), .onhook_monitor(onhook_monitor),
    .line_side_powerdown(line_side_powerdown), .system_side_powerdown(system_side_powerdown),
    .tx_atten_db(tx_atten_db), .tx_mute(tx_mute), .rx_atten_db(rx_atten_db),
    .rx_mute(rx_mute), .irq(irq));

  line_side_model far_end (.mclk(mclk), .ring_cmd(ring_cmd),
    .line_side_powerdown(line_side_powerdown), .ring_neg(ring_neg), .ring_pos(ring_pos));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // expected {mute, attenuation} per level code
  function automatic logic [6:0] tx_exp(input logic [1:0] c);
    case (c)
      2'b00: return 7'h14;
      2'b01: return 7'h20;
      2'b10: return 7'h40;
      default: return 7'h1a;
    endcase
  endfunction

  function automatic logic [6:0] rx_exp(input logic [1:0] c);
    case (c)
      2'b00: return 7'h00;
      2'b01: return 7'h0c;
      2'b10: return 7'h40;
      default: return 7'h06;
    endcase
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one avalon cycle: hold until waitrequest is seen low at a rising edge;
  // the bench only ever addresses registers of the map
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      finish_test();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one more edge so a write has landed before the caller looks
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    idle(5);
    rstn <= 1'b1;
    idle(4);
    rd(A5, 8'h00);
    rd(A6, `CTRL_TWO_RST);
    `CHK(line_side_powerdown, 1'b1)
    // level codes in every combination, random filler in reserved bits
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      v = {seed[7], i[3], i[1], seed[4], 1'b0, seed[2], i[2], i[0]};
      bus(1'b1, A6, v);
      rd(A6, v & 8'h73);
      `CHK({tx_mute, tx_atten_db}, tx_exp(i[3:2]))
      `CHK({rx_mute, rx_atten_db}, rx_exp(i[1:0]))
      `CHK(line_side_powerdown, v[4])
    end
    // system-side power-down sticks until the restart pulse
    // clock runs from the start, so clearing line power-down here is legal
    bus(1'b1, A6, 8'h08);
    bus(1'b1, A6, 8'h00);
    rd(A6, 8'h08);
    `CHK(system_side_powerdown, 1'b1)
    bus(1'b1, ACF, 8'h04);
    idle(2);
    `CHK(system_side_powerdown, 1'b0)
    // a write without lane 0 enabled is ignored
    avs_byteenable <= 4'he;
    bus(1'b1, A6, 8'h73);
    avs_byteenable <= 4'hf;
    rd(A6, 8'h00);
    `CHK(line_side_powerdown, 1'b0)
    // reserved register and reserved bits
    bus(1'b1, A7, seed[15:8]);
    rd(A7, 8'h00);
    bus(1'b1, A5, 8'hf6);
    rd(A5, 8'h00);
    // ring events, masked then unmasked interrupt
    ring_cmd <= 2'b01;
    idle(3);
    rd(A5, 8'h24);
    rd(AST, 8'h01);
    `CHK(irq, 1'b0)
    bus(1'b1, AMK, 8'h03);
    `CHK(irq, 1'b1)
    ring_cmd <= 2'b10;
    idle(3);
    rd(A5, 8'h44);
    ring_cmd <= 2'b00;
    idle(30);
    rd(A5, 8'h00);
    rd(AST, 8'h03);
    bus(1'b1, AST, 8'h03);
    rd(AST, 8'h00);
    `CHK(irq, 1'b0)
    // monitor mode, cleared again before going off-hook
    bus(1'b1, A5, 8'h08);
    `CHK(onhook_monitor, 1'b1)
    bus(1'b1, A5, 8'h00);
    bus(1'b1, A5, 8'h01);
    idle(2);
    `CHK(offhook_out, 1'b1)
    ring_cmd <= 2'b01;
    idle(3);
    rd(A5, 8'h21);
    ring_cmd <= 2'b00;
    bus(1'b1, ACF, 8'h01);
    idle(2);
    `CHK(offhook_out, 1'b0)
    bus(1'b1, ACF, 8'h00);
    idle(2);
    `CHK(offhook_out, 1'b1)
    bus(1'b1, A5, 8'h00);
    idle(20);
    `CHK(offhook_out, 1'b0)
    // off-hook pin counts only while enabled
    offhook_pin <= 1'b1;
    idle(3);
    `CHK(offhook_out, 1'b0)
    bus(1'b1, ACF, 8'h02);
    idle(2);
    `CHK(offhook_out, 1'b1)
    // clock enable low freezes the hook state although the pin drops
    ce <= 1'b0;
    offhook_pin <= 1'b0;
    idle(4);
    `CHK(offhook_out, 1'b1)
    ce <= 1'b1;
    idle(2);
    `CHK(offhook_out, 1'b0)
    finish_test();
  end

  // a hang anywhere ends the run as a failure
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule

// ==== verilog/line_if_defs.svh ====
// constants of the line interface control register bank
`ifndef LINE_IF_DEFS_SVH
`define LINE_IF_DEFS_SVH
// register indexes, byte address is four times the index
`define IDX_CTRL_ONE 6'h05
`define IDX_CTRL_TWO 6'h06
`define IDX_RSVD_SEVEN 6'h07
`define IDX_IRQ_STATUS 6'h08
`define IDX_IRQ_MASK 6'h09
`define IDX_CONFIG 6'h0a
// line_control_one fields
`define B_RING_NEG 6
`define B_RING_POS 5
`define B_ONHOOK_MONITOR_ENABLE 3
`define B_RDT 2
`define B_OH 0
`define CTRL_ONE_WMASK 8'h09
// line_control_two fields
`define B_TX_HI 6
`define B_RX_HI 5
`define B_PDL 4
`define B_PDN 3
`define B_TX_LO 1
`define B_RX_LO 0
`define CTRL_TWO_RST 8'h70
`define CTRL_TWO_WMASK 8'h73
// config and interrupt fields
`define B_MODE 0
`define B_PIN_EN 1
`define B_SYS_RESTART 2
`define B_EV_RING_ON 0
`define B_EV_RING_OFF 1
// timing
`define MCLK_KHZ 125000
`define MCLK_MHZ 125
`define RING_HOLD_MS 4500
`define RING_HOLD_CYC (64'(`RING_HOLD_MS) * 64'(`MCLK_KHZ))
`define OFFHOOK_HOLD_US 1000
`define OFFHOOK_HOLD_CYC (64'(`OFFHOOK_HOLD_US) * 64'(`MCLK_MHZ))
`endif

// ==== verilog/line_if_pkg.sv ====
// types of the line interface control register bank
package line_if_pkg;
  typedef enum logic [1:0] {HOOK_ON, HOOK_OFF, HOOK_HOLDOFF} hook_state_e;
  typedef logic [1:0] level_code_t;
  typedef logic [7:0] reg8_t;
endpackage

// ==== verilog/line_interface_control_regs.sv ====
// line interface control registers five to seven behind an avalon-mm slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "line_if_defs.svh"

// Overview of operation
// - negative-ring flag, reg five bit 6, follows negative ring presence.
// - positive-ring flag, reg five bit 5, follows positive ring presence.
// - ring indicator sets on ring, clears 4.5 s after last ring or off-hook.
// - on-hook monitor bit puts the line side in low-power monitoring.
// - off-hook is the request bit ORed with the enabled off-hook pin.
// - mode bit forces on-hook without hold-off, immediate return when cleared.
// - transmit level field picks -20, -32 dB, mute or -26 dB.
// - receive level field picks 0, -12 dB, mute or -6 dB.
// - line-side power-down bit lowers line-side chip power.
// - system power-down sticks until the internal restart of that module.
module line_interface_control_regs
  import line_if_pkg::*;
#(
  parameter logic [29:0] RING_HOLD_CYC = 30'(`RING_HOLD_CYC),
  parameter logic [16:0] OFFHOOK_HOLD_CYC = 17'(`OFFHOOK_HOLD_CYC)
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ring_neg_in,
  input wire logic ring_pos_in,
  input wire logic offhook_pin,
  output logic offhook_out,
  output logic onhook_monitor,
  output logic line_side_powerdown,
  output logic system_side_powerdown,
  output logic [5:0] tx_atten_db,
  output logic tx_mute,
  output logic [5:0] rx_atten_db,
  output logic rx_mute,
  output logic irq
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // async assert, release after two edges
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // attenuation magnitude in dB for a level code, tx table or rx table
  function automatic logic [5:0] atten(input level_code_t code, input logic is_tx);
    case (code)
      2'b00: atten = is_tx ? 6'd20 : 6'd0;
      2'b01: atten = is_tx ? 6'd32 : 6'd12;
      2'b11: atten = is_tx ? 6'd26 : 6'd6;
      default: atten = 6'd0;
    endcase
  endfunction

  logic ack_reg;
  reg8_t one_reg;
  reg8_t two_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] cfg_reg;
  logic rdt_reg;
  logic [29:0] ring_cnt_reg;
  logic [16:0] hold_cnt_reg;
  hook_state_e hook_state;
  logic [31:0] rdata_reg;

  // one wait cycle, answer in the second cycle of every request while ce stays high
  wire req = avs_read | avs_write;
  wire wr_go = ce & avs_write & ack_reg & avs_byteenable[0];
  wire sel_one = hit(avs_address, `IDX_CTRL_ONE);
  wire sel_two = hit(avs_address, `IDX_CTRL_TWO);
  wire sel_stat = hit(avs_address, `IDX_IRQ_STATUS);
  wire sel_mask = hit(avs_address, `IDX_IRQ_MASK);
  wire sel_cfg = hit(avs_address, `IDX_CONFIG);
  wire [7:0] wdata = avs_writedata[7:0];
  wire mode = cfg_reg[`B_MODE];
  wire pin_en = cfg_reg[`B_PIN_EN];
  wire sys_restart = wr_go & sel_cfg & wdata[`B_SYS_RESTART];

  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  // read view, reserved positions are constant zero
  wire [7:0] one_view = {1'b0, ring_neg_in, ring_pos_in, 1'b0,
                         one_reg[`B_ONHOOK_MONITOR_ENABLE], rdt_reg, 1'b0, one_reg[`B_OH]};
  wire [7:0] two_view = two_reg & `CTRL_TWO_WMASK | {4'h0, system_side_powerdown, 3'h0};
  wire [7:0] rd_mux = sel_one ? one_view :
                      sel_two ? two_view :
                      sel_stat ? {6'h00, status_reg} :
                      sel_mask ? {6'h00, mask_reg} :
                      sel_cfg ? {6'h00, cfg_reg} : 8'h00;

  // handshake and read capture; unmapped and register seven read zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg)
        rdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // power-down of system side lives outside two_reg since a zero write must not clear it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      one_reg <= 8'h00;
      two_reg <= `CTRL_TWO_RST;
      cfg_reg <= 2'b00;
      mask_reg <= 2'b00;
      system_side_powerdown <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_go & sel_one)
        one_reg <= wdata & `CTRL_ONE_WMASK;
      if (wr_go & sel_two)
        two_reg <= wdata & `CTRL_TWO_WMASK;
      if (wr_go & sel_cfg)
        cfg_reg <= wdata[1:0];
      if (wr_go & sel_mask)
        mask_reg <= wdata[1:0];
      if (sys_restart)
        system_side_powerdown <= 1'b0;
      else if (wr_go & sel_two & wdata[`B_PDN])
        system_side_powerdown <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // hook control
  // ---------------------------------------------------------------
  // hold-off after a normal on-hook keeps the line from bouncing straight back
  wire want_off = one_reg[`B_OH] | (offhook_pin & pin_en);
  hook_state_e hook_next;
  always_comb
  begin
    hook_next = hook_state;
    case (hook_state)
      HOOK_ON:
        if (want_off & ~mode)
          hook_next = HOOK_OFF;
      HOOK_OFF:
        if (mode)
          hook_next = HOOK_ON;
        else if (~want_off)
          hook_next = HOOK_HOLDOFF;
      HOOK_HOLDOFF:
        if (mode | (hold_cnt_reg == 17'd1))
          hook_next = HOOK_ON;
      default:
        hook_next = HOOK_ON;
    endcase
  end

  // hook state and hold-off counter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hook_state <= HOOK_ON;
      hold_cnt_reg <= 17'd0;
    end
    else if (ce)
    begin
      hook_state <= hook_next;
      if (hook_next == HOOK_HOLDOFF && hook_state == HOOK_OFF)
        hold_cnt_reg <= OFFHOOK_HOLD_CYC;
      else if (hold_cnt_reg != 17'd0)
        hold_cnt_reg <= hold_cnt_reg - 17'd1;
    end
  end

  assign offhook_out = (hook_state == HOOK_OFF);
  assign onhook_monitor = one_reg[`B_ONHOOK_MONITOR_ENABLE] & ~offhook_out;

  // ---------------------------------------------------------------
  // ring indicator and interrupts
  // ---------------------------------------------------------------
  // the hold time uses the short end of the allowed window
  wire ring_any = ring_neg_in | ring_pos_in;
  wire rdt_next = offhook_out ? 1'b0 :
                  ring_any ? 1'b1 :
                  (ring_cnt_reg == 30'd1) ? 1'b0 : rdt_reg;
  wire [1:0] events = {rdt_reg & ~rdt_next, rdt_next & ~rdt_reg};
  wire [1:0] w1c = (wr_go & sel_stat) ? wdata[1:0] : 2'b00;

  // events win over a same-cycle clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdt_reg <= 1'b0;
      ring_cnt_reg <= 30'd0;
      status_reg <= 2'b00;
    end
    else if (ce)
    begin
      rdt_reg <= rdt_next;
      if (ring_any)
        ring_cnt_reg <= RING_HOLD_CYC;
      else if (ring_cnt_reg != 30'd0)
        ring_cnt_reg <= ring_cnt_reg - 30'd1;
      status_reg <= (status_reg & ~w1c) | events;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // call-progress levels and line-side power
  // ---------------------------------------------------------------
  wire [1:0] tx_code = {two_reg[`B_TX_HI], two_reg[`B_TX_LO]};
  wire [1:0] rx_code = {two_reg[`B_RX_HI], two_reg[`B_RX_LO]};

  // registered so the analog side sees glitch-free codes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_atten_db <= 6'd0;
      tx_mute <= 1'b0;
      rx_atten_db <= 6'd0;
      rx_mute <= 1'b0;
      line_side_powerdown <= 1'b1;
    end
    else if (ce)
    begin
      tx_atten_db <= atten(tx_code, 1'b1);
      tx_mute <= (tx_code == 2'b10);
      rx_atten_db <= atten(rx_code, 1'b0);
      rx_mute <= (rx_code == 2'b10);
      line_side_powerdown <= two_reg[`B_PDL];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire rd_done = avs_read & ~avs_waitrequest;

  a_ring_neg_read: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_done && sel_one && $past(ce) |-> avs_readdata[6] == $past(ring_neg_in))
    else $error("negative ring flag read wrong");
  a_ring_pos_read: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_done && sel_one && $past(ce) |-> avs_readdata[5] == $past(ring_pos_in))
    else $error("positive ring flag read wrong");
  a_ring_offhook_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && offhook_out |=> !rdt_reg)
    else $error("ring indicator not cleared off-hook");
  a_ring_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ring_any && !offhook_out |=> rdt_reg && ring_cnt_reg == RING_HOLD_CYC)
    else $error("ring indicator not set on ring");
  a_monitor_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    one_reg[`B_ONHOOK_MONITOR_ENABLE] && hook_state != HOOK_OFF |-> onhook_monitor)
    else $error("monitor mode missing on-hook");
  a_offhook_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && want_off && !mode && hook_state == HOOK_ON |=> offhook_out)
    else $error("off-hook request not followed");
  a_mode_onhook: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && mode && offhook_out |=> hook_state == HOOK_ON && hold_cnt_reg == $past(hold_cnt_reg))
    else $error("mode bit did not drop hook cleanly");
  a_tx_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && tx_code == 2'b01 |=> tx_atten_db == 6'd32 && !tx_mute)
    else $error("transmit level wrong");
  a_rx_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rx_code == 2'b10 |=> rx_mute)
    else $error("receive mute wrong");
  a_line_pd: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && sel_two ##1 ce |=> line_side_powerdown == $past(wdata[`B_PDL], 2))
    else $error("line power-down not applied");
  a_sys_pd_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    system_side_powerdown && !sys_restart |=> system_side_powerdown)
    else $error("system power-down released early");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_done && (hit(avs_address, `IDX_RSVD_SEVEN) || sel_one) |->
    (avs_readdata & 32'hffff_ff92) == 32'h0000_0000)
    else $error("reserved bits not zero");

  c_ring_cycle: cover property (@(posedge mclk) disable iff (!rst_n) $fell(rdt_reg));
  c_offhook: cover property (@(posedge mclk) disable iff (!rst_n) $rose(offhook_out));
  c_holdoff: cover property (@(posedge mclk) disable iff (!rst_n) hook_state == HOOK_HOLDOFF);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));

endmodule
